/* su_pkg.sv */
package su_pkg;

   // ************************************************************
   // Bus geometry and register offsets.
   // ************************************************************
   localparam int SU_AW = 3; // Register address width.
   localparam int SU_DW = 8; // Register data width.
   localparam logic [2:0] SU_OFS_MODE = 3'h0; // Mode register.
   localparam logic [2:0] SU_OFS_CTRL = 3'h1; // Control register.
   localparam logic [2:0] SU_OFS_RATE = 3'h2; // Bit rate register.
   localparam logic [2:0] SU_OFS_TXD = 3'h3; // Transmit data register.
   localparam logic [2:0] SU_OFS_STAT = 3'h4; // Status register.
   localparam logic [2:0] SU_OFS_RXD = 3'h5; // Receive data register.

   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int SU_MODE_SYNC = 0; // One selects the clocked mode.
   localparam int SU_CTRL_TIE = 7; // Transmit request enable.
   localparam int SU_CTRL_RIE = 6; // Receive request enable.
   localparam int SU_CTRL_TE = 5; // Transmit enable.
   localparam int SU_CTRL_RE = 4; // Receive enable.
   localparam int SU_CTRL_CKS1 = 1; // Clock source select, high bit.
   localparam int SU_CTRL_CKS0 = 0; // Clock source select, low bit.
   localparam int SU_STAT_TXE = 7; // Transmit empty flag.
   localparam int SU_STAT_RXF = 6; // Receive full flag.
   localparam int SU_STAT_OVR = 5; // Overrun flag.
   localparam int SU_STAT_FRM = 4; // Framing fault flag.
   localparam int SU_STAT_PAR = 3; // Parity fault flag.

   // ************************************************************
   // Reset values and counts.
   // ************************************************************
   localparam logic [7:0] SU_CTRL_RST = 8'h00; // All disabled.
   localparam logic [7:0] SU_RATE_RST = 8'hFF; // Slowest rate.
   localparam logic [7:0] SU_DATA_RST = 8'h00; // Data registers clear.
   localparam logic [3:0] SU_CHAR_BITS = 4'h8; // Bits per character.
   localparam logic [3:0] SU_LAST_BIT = 4'h7; // Index of the last bit.
   localparam logic [3:0] SU_CNT_RST = 4'h0; // Bit counter start.
   localparam logic [1:0] SU_IRQ_NONE = 2'h0; // No request pending.
   localparam logic [1:0] SU_IRQ_TX = 2'h1; // Transmit-end leads.
   localparam logic [1:0] SU_IRQ_RX = 2'h2; // Receive-end leads.
   localparam logic [1:0] SU_IRQ_ERR = 2'h3; // Receive-error leads.

   // ************************************************************
   // Types.
   // ************************************************************
   typedef enum logic [1:0]
   {
      SU_TX_IDLE = 2'b01,
      SU_TX_SHIFT = 2'b10
   } su_tx_state_t;

   // One register bus request.
   typedef struct packed
   {
      logic [SU_AW-1:0] addr;
      logic [SU_DW-1:0] wdata;
      logic wr;
      logic rd;
      logic xfer;
   } su_bus_req_t;

   // Whole state of the serial unit.
   typedef struct packed
   {
      logic mode_sync;
      logic [7:0] ctrl;
      logic [7:0] rate;
      logic [7:0] tx_data_reg;
      logic [7:0] tx_shift_reg;
      logic [7:0] rx_data_reg;
      logic [7:0] rx_shift_reg;
      logic tx_empty;
      logic rx_full;
      logic overrun;
      logic framing;
      logic parity;
      logic [4:0] seen;
      su_tx_state_t tx_state;
      logic [3:0] tx_cnt;
      logic [3:0] rx_cnt;
      logic txd;
      logic [7:0] baud_cnt;
      logic sck_int;
      logic sck_s1;
      logic sck_s2;
      logic sck_prev;
      logic rxd_s1;
      logic rxd_s2;
      logic [7:0] rdata;
   } su_state_t;

   localparam su_state_t SU_STATE_RST = '{
      mode_sync: 1'b0, ctrl: SU_CTRL_RST, rate: SU_RATE_RST, tx_data_reg: SU_DATA_RST,
      tx_shift_reg: SU_DATA_RST, rx_data_reg: SU_DATA_RST, rx_shift_reg: SU_DATA_RST, tx_empty: 1'b1,
      rx_full: 1'b0, overrun: 1'b0, framing: 1'b0, parity: 1'b0, seen: 5'h00,
      tx_state: SU_TX_IDLE, tx_cnt: SU_CNT_RST, rx_cnt: SU_CNT_RST, txd: 1'b1,
      baud_cnt: SU_RATE_RST, sck_int: 1'b1, sck_s1: 1'b1, sck_s2: 1'b1,
      sck_prev: 1'b1, rxd_s1: 1'b1, rxd_s2: 1'b1, rdata: SU_DATA_RST};

endpackage : su_pkg

/* su_sync_serial.sv */
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module su_sync_serial
(
   input wire logic core_clk_in, // System clock, 50 MHz.
   input wire logic rst_b_in, // Asynchronous reset, active low.
   input wire su_pkg::su_bus_req_t bus_req_in, // Register bus request.
   output logic [7:0] rd_data_out, // Read data, one cycle after the strobe.
   input wire logic rxd_in, // Receive data pin.
   output logic txd_out, // Transmit data pin.
   output logic txd_oe_b_out, // Transmit pin enable, low drives.
   input wire logic sck_in, // Clock pin, level seen on the wire.
   output logic sck_out, // Clock pin, driven level.
   output logic sck_oe_b_out, // Clock pin enable, low drives.
   output logic tx_done_irq_out, // Transmit-end request.
   output logic rx_done_irq_out, // Receive-end request.
   output logic rx_fault_irq_out, // Receive-error request.
   output logic [1:0] irq_top_out, // Highest-priority pending request.
   output logic xfer_req_out // A request the transfer controller may serve.
);
   import su_pkg::*;

   // ************************************************************
   // State and decoded controls.
   // ************************************************************
   su_state_t st_reg; // Registered state.
   su_state_t st_next; // Next state.
   logic tx_enable; // Transmitter enabled.
   logic rx_enable; // Receiver enabled.
   logic tx_irq_enable; // Transmit request enable.
   logic rx_irq_enable; // Receive request enable.
   logic clock_source_sel0; // Clock source select, low bit.
   logic clock_source_sel1; // Clock source select, high bit.
   logic int_clk; // Clocked mode on the internal generator.
   logic ext_clk; // Clocked mode on the pin clock.
   logic sck_drive; // Clock pin driven by us.
   logic rx_go; // Receiver allowed to take bits.
   logic run_clk; // Internal clock may toggle.
   logic tick; // Half bit period elapsed.
   logic fall_edge; // Serial clock fell.
   logic rise_edge; // Serial clock rose.
   logic tx_load; // Transmit data moves into the shift register.
   logic [7:0] rsr_new; // Shift register with this bit added.
   logic tx_done_irq; // Transmit-end request level.
   logic rx_done_irq; // Receive-end request level.
   logic rx_fault_irq; // Receive-error request level.
   logic [7:0] stat_view; // Status register as read.

   // Decode the status fields as software sees them.
   function automatic logic [7:0] su_stat(input su_state_t s);
      logic [7:0] v;
      v = 8'h00;
      v[SU_STAT_TXE] = s.tx_empty;
      v[SU_STAT_RXF] = s.rx_full;
      v[SU_STAT_OVR] = s.overrun;
      v[SU_STAT_FRM] = s.framing;
      v[SU_STAT_PAR] = s.parity;
      return v;
   endfunction : su_stat

   // ************************************************************
   // Control decode and clock selection.
   // ************************************************************

   // Individual control bits pulled from the control register.
   always_comb
   begin
      tx_enable = st_reg.ctrl[SU_CTRL_TE];
      rx_enable = st_reg.ctrl[SU_CTRL_RE];
      tx_irq_enable = st_reg.ctrl[SU_CTRL_TIE];
      rx_irq_enable = st_reg.ctrl[SU_CTRL_RIE];
      clock_source_sel0 = st_reg.ctrl[SU_CTRL_CKS0];
      clock_source_sel1 = st_reg.ctrl[SU_CTRL_CKS1];
   end

   // Clock source and pin direction; in asynchronous mode the pin only drives on the
   // low select bit, so setting the mode before the sources can briefly drive the pin.
   always_comb
   begin
      int_clk = st_reg.mode_sync & ~clock_source_sel1;
      ext_clk = st_reg.mode_sync & clock_source_sel1;
      if (st_reg.mode_sync)
      begin
         sck_drive = ~clock_source_sel1;
      end
      else
      begin
         sck_drive = clock_source_sel0 & ~clock_source_sel1;
      end
   end

   // With both directions on, reception waits for a transmission to run, so the two
   // start together; receive alone starts at once.
   always_comb
   begin
      rx_go = rx_enable & (~tx_enable | (st_reg.tx_state == SU_TX_SHIFT));
      if (int_clk)
      begin
         run_clk = (st_reg.tx_state == SU_TX_SHIFT) | rx_go;
      end
      else
      begin
         run_clk = sck_drive;
      end
      tick = run_clk & (st_reg.baud_cnt == 8'h00);
   end

   // Serial clock edges from the generator or from the synchronised pin. Only the second
   // stage and its delayed copy are compared; the first stage may be metastable.
   always_comb
   begin
      if (int_clk)
      begin
         fall_edge = tick & st_reg.sck_int;
         rise_edge = tick & ~st_reg.sck_int;
      end
      else if (ext_clk)
      begin
         fall_edge = st_reg.sck_prev & ~st_reg.sck_s2;
         rise_edge = ~st_reg.sck_prev & st_reg.sck_s2;
      end
      else
      begin
         fall_edge = 1'b0;
         rise_edge = 1'b0;
      end
   end

   // ************************************************************
   // Requests to the interrupt controller.
   // ************************************************************

   // Each request follows its flag behind its enable; the receive-error request shares the receive enable.
   always_comb
   begin
      tx_done_irq = st_reg.tx_empty & tx_irq_enable;
      rx_done_irq = st_reg.rx_full & rx_irq_enable;
      rx_fault_irq = (st_reg.overrun | st_reg.framing | st_reg.parity) & rx_irq_enable;
      stat_view = su_stat(st_reg);
   end

   // ************************************************************
   // Next state.
   // ************************************************************

   // All updates for one cycle. Clears are applied first and sets after, so a flag set
   // by hardware in the same cycle as a clear survives.
   always_comb
   begin
      st_next = st_reg;
      rsr_new = st_reg.rx_shift_reg;
      tx_load = 1'b0;

      // Pin synchronisers.
      st_next.sck_s1 = sck_in;
      st_next.sck_s2 = st_reg.sck_s1;
      st_next.sck_prev = st_reg.sck_s2;
      st_next.rxd_s1 = rxd_in;
      st_next.rxd_s2 = st_reg.rxd_s1;

      // Bit rate generator; it parks high so a stopped clock leaves the pin idle.
      if (run_clk)
      begin
         if (tick)
         begin
            st_next.baud_cnt = st_reg.rate;
            st_next.sck_int = ~st_reg.sck_int;
         end
         else
         begin
            st_next.baud_cnt = st_reg.baud_cnt - 8'h01;
         end
      end
      else
      begin
         st_next.baud_cnt = st_reg.rate;
         st_next.sck_int = 1'b1;
      end

      // Register reads; data appear in the following cycle.
      st_next.rdata = 8'h00;
      if (bus_req_in.rd)
      begin
         unique case (bus_req_in.addr)
            SU_OFS_MODE: st_next.rdata = {7'h00, st_reg.mode_sync};
            SU_OFS_CTRL: st_next.rdata = st_reg.ctrl;
            SU_OFS_RATE: st_next.rdata = st_reg.rate;
            SU_OFS_TXD: st_next.rdata = st_reg.tx_data_reg;
            SU_OFS_STAT:
            begin
               st_next.rdata = stat_view;
               // Remember which flags software has seen set.
               st_next.seen = {st_reg.tx_empty, st_reg.rx_full, st_reg.overrun,
                  st_reg.framing, st_reg.parity};
            end
            SU_OFS_RXD:
            begin
               st_next.rdata = st_reg.rx_data_reg;
               if (bus_req_in.xfer & rx_done_irq)
               begin
                  st_next.rx_full = 1'b0;
               end
            end
            default: st_next.rdata = 8'h00;
         endcase
      end

      // Register writes.
      if (bus_req_in.wr)
      begin
         unique case (bus_req_in.addr)
            SU_OFS_MODE: st_next.mode_sync = bus_req_in.wdata[SU_MODE_SYNC];
            SU_OFS_CTRL: st_next.ctrl = bus_req_in.wdata;
            SU_OFS_RATE: st_next.rate = bus_req_in.wdata;
            SU_OFS_TXD:
            begin
               // The byte may be replaced while the shifter is busy.
               st_next.tx_data_reg = bus_req_in.wdata;
               if (bus_req_in.xfer & tx_done_irq)
               begin
                  st_next.tx_empty = 1'b0;
               end
            end
            SU_OFS_STAT:
            begin
               // A zero clears a flag only after it was read as set; ones do nothing.
               if (~bus_req_in.wdata[SU_STAT_TXE] & st_reg.seen[4])
               begin
                  st_next.tx_empty = 1'b0;
               end
               if (~bus_req_in.wdata[SU_STAT_RXF] & st_reg.seen[3])
               begin
                  st_next.rx_full = 1'b0;
               end
               if (~bus_req_in.wdata[SU_STAT_OVR] & st_reg.seen[2])
               begin
                  st_next.overrun = 1'b0;
               end
               if (~bus_req_in.wdata[SU_STAT_FRM] & st_reg.seen[1])
               begin
                  st_next.framing = 1'b0;
               end
               if (~bus_req_in.wdata[SU_STAT_PAR] & st_reg.seen[0])
               begin
                  st_next.parity = 1'b0;
               end
               st_next.seen = 5'h00;
            end
            default:
            begin
               // Unmapped writes are dropped.
            end
         endcase
      end

      // Transmitter. A pending overrun keeps it from starting.
      if (~tx_enable | ~st_reg.mode_sync)
      begin
         st_next.tx_state = SU_TX_IDLE;
         st_next.tx_cnt = SU_CNT_RST;
         st_next.txd = 1'b1;
      end
      else
      begin
         unique case (st_reg.tx_state)
            SU_TX_IDLE:
            begin
               if (~st_reg.tx_empty & ~st_reg.overrun)
               begin
                  tx_load = 1'b1;
                  st_next.tx_state = SU_TX_SHIFT;
                  st_next.tx_cnt = SU_CNT_RST;
               end
               else if (fall_edge & ext_clk)
               begin
                  st_next.txd = 1'b1;
               end
               // With the internal clock stopped the last bit simply stays.
            end
            SU_TX_SHIFT:
            begin
               if (fall_edge & (st_reg.tx_cnt < SU_CHAR_BITS))
               begin
                  st_next.txd = st_reg.tx_shift_reg[st_reg.tx_cnt[2:0]];
                  st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
               end
               else if (rise_edge & (st_reg.tx_cnt == SU_CHAR_BITS))
               begin
                  if (~st_reg.tx_empty & ~st_reg.overrun)
                  begin
                     tx_load = 1'b1;
                     st_next.tx_cnt = SU_CNT_RST;
                  end
                  else
                  begin
                     st_next.tx_state = SU_TX_IDLE;
                  end
               end
            end
         endcase
      end
      if (tx_load)
      begin
         st_next.tx_shift_reg = st_reg.tx_data_reg;
         st_next.tx_empty = 1'b1;
      end

      // Receiver. Bits enter LSB first; an overrun freezes it until cleared.
      if (~rx_enable | ~st_reg.mode_sync)
      begin
         st_next.rx_cnt = SU_CNT_RST;
      end
      else if (rise_edge & rx_go & ~st_reg.overrun)
      begin
         rsr_new[st_reg.rx_cnt[2:0]] = st_reg.rxd_s2;
         st_next.rx_shift_reg = rsr_new;
         if (st_reg.rx_cnt == SU_LAST_BIT)
         begin
            st_next.rx_cnt = SU_CNT_RST;
            if (st_reg.rx_full)
            begin
               st_next.overrun = 1'b1;
            end
            else
            begin
               st_next.rx_data_reg = rsr_new;
               st_next.rx_full = 1'b1;
            end
         end
         else
         begin
            st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
         end
      end
   end

   // ************************************************************
   // State register.
   // ************************************************************

   // Single register for the whole state.
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         st_reg <= SU_STATE_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // Outputs.
   // ************************************************************

   // Pins, read data and request lines. Priority and controller service are offered
   // here; only the two data requests may be served by the transfer controller.
   always_comb
   begin
      rd_data_out = st_reg.rdata;
      txd_out = st_reg.txd;
      txd_oe_b_out = ~(tx_enable & st_reg.mode_sync);
      sck_out = st_reg.sck_int;
      sck_oe_b_out = ~sck_drive;
      tx_done_irq_out = tx_done_irq;
      rx_done_irq_out = rx_done_irq;
      rx_fault_irq_out = rx_fault_irq;
      xfer_req_out = tx_done_irq | rx_done_irq;
      if (rx_fault_irq)
      begin
         irq_top_out = SU_IRQ_ERR;
      end
      else if (rx_done_irq)
      begin
         irq_top_out = SU_IRQ_RX;
      end
      else if (tx_done_irq)
      begin
         irq_top_out = SU_IRQ_TX;
      end
      else
      begin
         irq_top_out = SU_IRQ_NONE;
      end
   end

endmodule : su_sync_serial

/* su_sync_serial_assertions.sv */
`timescale 1ns/1ps
// Port-level checker for the clocked serial unit.
module su_sync_serial_chk
(
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire su_pkg::su_bus_req_t bus_req_in,
   input wire logic [7:0] rd_data_out,
   input wire logic txd_out,
   input wire logic txd_oe_b_out,
   input wire logic sck_out,
   input wire logic sck_oe_b_out,
   input wire logic tx_done_irq_out,
   input wire logic rx_done_irq_out,
   input wire logic rx_fault_irq_out,
   input wire logic [1:0] irq_top_out,
   input wire logic xfer_req_out
);
   import su_pkg::*;
   // ************************************************************
   // Every check runs on the one system clock.
   // ************************************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   rd_idle_a: assert property (!bus_req_in.rd |=> rd_data_out == 8'h00) else $error("read data outlived its cycle");
   unmapped_a: assert property (bus_req_in.rd && bus_req_in.addr > 3'h5 |=> rd_data_out == 8'h00)
      else $error("unmapped read returned data");
   xfer_req_a: assert property (xfer_req_out == (tx_done_irq_out | rx_done_irq_out))
      else $error("controller request mismatch");
   prio_err_a: assert property (rx_fault_irq_out |-> irq_top_out == SU_IRQ_ERR)
      else $error("error request not on top");
   prio_rx_a: assert property (!rx_fault_irq_out && rx_done_irq_out |-> irq_top_out == SU_IRQ_RX)
      else $error("receive request not on top");
   prio_tx_a: assert property ({rx_fault_irq_out, rx_done_irq_out, tx_done_irq_out} == 3'b001 |->
      irq_top_out == SU_IRQ_TX) else $error("transmit request not on top");
   txd_fall_a: assert property (!txd_oe_b_out && !sck_oe_b_out && $changed(txd_out) |-> !sck_out)
      else $error("transmit pin moved with clock high");
   ovr_full_a: assert property ($rose(rx_fault_irq_out) |-> rx_done_irq_out)
      else $error("overrun without full buffer");
   rx_xfer_a: assert property (bus_req_in.rd && bus_req_in.xfer && bus_req_in.addr == SU_OFS_RXD &&
      rx_done_irq_out && rx_fault_irq_out |=> !rx_done_irq_out) else $error("controller read kept full");
   tx_xfer_a: assert property (bus_req_in.wr && bus_req_in.xfer && bus_req_in.addr == SU_OFS_TXD &&
      tx_done_irq_out |=> !tx_done_irq_out) else $error("controller write kept empty");
   clear_only_a: assert property (bus_req_in.wr && bus_req_in.addr == SU_OFS_STAT &&
      !rx_fault_irq_out && !rx_done_irq_out |=> !rx_fault_irq_out) else $error("status write set a flag");
   cover property ($rose(rx_fault_irq_out));
   cover property (bus_req_in.wr && bus_req_in.xfer);
   cover property ($fell(sck_out) && !sck_oe_b_out);
endmodule : su_sync_serial_chk
bind su_sync_serial su_sync_serial_chk i_chk (.core_clk_in, .rst_b_in, .bus_req_in, .rd_data_out, .txd_out,
   .txd_oe_b_out, .sck_out, .sck_oe_b_out, .tx_done_irq_out, .rx_done_irq_out, .rx_fault_irq_out,
   .irq_top_out, .xfer_req_out);

/* su_peer.sv */
`timescale 1ns/1ps
// Far-side peer: gathers the transmit pin on rising clock edges and sends its own byte from falling edges.
module su_peer
(
   input wire logic sck_in,
   input wire logic txd_in,
   input wire logic clr_in,
   input wire logic [7:0] tx_byte_in,
   output logic rxd_out,
   output logic [7:0] got_byte_out,
   output logic [7:0] got_cnt_out
);
   logic [7:0] cap_reg; // Bits gathered so far.
   logic [7:0] cur_reg; // Byte being sent, latched at its first bit so a late change cannot tear it.
   logic [2:0] in_cnt; // Gathered bit count.
   logic [2:0] out_cnt; // Sent bit count.
   initial rxd_out = 1'b1;
   // A clear realigns both counters to a character boundary and lets go of the data line.
   always @(posedge clr_in or posedge sck_in or negedge sck_in)
   begin
      if (clr_in)
      begin
         in_cnt = 3'h0;
         out_cnt = 3'h0;
         got_cnt_out = 8'h00;
         rxd_out = 1'b1;
      end
      else if (sck_in)
      begin
         cap_reg = {txd_in, cap_reg[7:1]};
         in_cnt = in_cnt + 3'h1;
         if (in_cnt == 3'h0)
         begin
            got_byte_out = cap_reg;
            got_cnt_out = got_cnt_out + 8'h01;
         end
      end
      else
      begin
         if (out_cnt == 3'h0)
            cur_reg = tx_byte_in;
         rxd_out = cur_reg[out_cnt];
         out_cnt = out_cnt + 3'h1;
      end
   end
endmodule : su_peer

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   import su_pkg::*;
   logic clk; // System clock.
   logic rst_b; // Reset, active low.
   su_bus_req_t bus_req; // Register bus request.
   logic [7:0] rd_data, rv, peer_byte, got_byte, got_cnt;
   logic txd, txd_oe_b, sck_out, sck_oe_b, rxd, sck_wire, tx_irq, rx_irq, err_irq, xfer_req, peer_clr;
   logic [1:0] irq_top;
   logic ext_sck; // Outside clock for the pin, idle high.
   int num_errors = 0;
   int total_checks = 0;
   // A released clock pin follows the outside clock, which idles high like a pull-up.
   assign sck_wire = sck_oe_b ? ext_sck : sck_out;
   su_sync_serial i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .bus_req_in(bus_req), .rd_data_out(rd_data),
      .rxd_in(rxd), .txd_out(txd), .txd_oe_b_out(txd_oe_b), .sck_in(sck_wire), .sck_out(sck_out),
      .sck_oe_b_out(sck_oe_b), .tx_done_irq_out(tx_irq), .rx_done_irq_out(rx_irq),
      .rx_fault_irq_out(err_irq), .irq_top_out(irq_top), .xfer_req_out(xfer_req));
   su_peer i_peer (.sck_in(sck_wire), .txd_in(txd), .clr_in(peer_clr), .tx_byte_in(peer_byte),
      .rxd_out(rxd), .got_byte_out(got_byte), .got_cnt_out(got_cnt));
   // ************************************************************
   // Shared helpers.
   // ************************************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // One bus cycle; a read leaves its answer in rv.
   task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w, input logic x);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: !w, xfer: x};
      @(posedge clk);
      bus_req <= '0;
      #1 rv = rd_data;
   endtask : bus
   task automatic tally_and_finish();
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic test_reset();
      chk("irqs", {tx_irq, rx_irq, err_irq}, 8'h00);
      bus(SU_OFS_CTRL, 8'h00, 1'b0, 1'b0);
      chk("ctrl", rv, SU_CTRL_RST);
      bus(SU_OFS_RATE, 8'h00, 1'b0, 1'b0);
      chk("rate", rv, SU_RATE_RST);
      bus(SU_OFS_STAT, 8'h00, 1'b0, 1'b0);
      chk("status", rv, 8'h80);
      bus(3'h7, 8'h00, 1'b0, 1'b0);
      chk("unmapped", rv, 8'h00);
      chk("sck_oe_b", sck_oe_b, 1'b1);
   endtask : test_reset
   // Two bytes back to back, the second loaded by the transfer controller.
   task automatic test_tx();
      bus(SU_OFS_MODE, 8'h01, 1'b1, 1'b0);
      bus(SU_OFS_RATE, 8'h03, 1'b1, 1'b0);
      chk("sck_oe_b", sck_oe_b, 1'b0);
      repeat (10) @(posedge clk);
      bus(SU_OFS_CTRL, 8'hA0, 1'b1, 1'b0);
      chk("txd_oe_b", txd_oe_b, 1'b0);
      chk("tx_irq", {tx_irq, xfer_req, irq_top}, {2'b11, SU_IRQ_TX});
      peer_clr <= 1'b1;
      @(posedge clk);
      peer_clr <= 1'b0;
      bus(SU_OFS_TXD, 8'hA5, 1'b1, 1'b0);
      bus(SU_OFS_STAT, 8'h00, 1'b0, 1'b0);
      bus(SU_OFS_STAT, 8'h7F, 1'b1, 1'b0);
      for (int i = 0; i < 20 && tx_irq !== 1'b1; i++) @(posedge clk);
      chk("tx_irq", tx_irq, 1'b1);
      bus(SU_OFS_TXD, 8'h3C, 1'b1, 1'b1);
      chk("tx_irq", tx_irq, 1'b0);
      for (int i = 0; i < 300 && got_cnt !== 8'h01; i++) @(posedge clk);
      chk("byte1", got_byte, 8'hA5);
      for (int i = 0; i < 300 && got_cnt !== 8'h02; i++) @(posedge clk);
      chk("byte2", got_byte, 8'h3C);
      repeat (40) @(posedge clk);
      chk("parked", {sck_out, txd}, 8'h02);
      chk("byte_count", got_cnt, 8'h02);
      bus(SU_OFS_CTRL, 8'h00, 1'b1, 1'b0);
   endtask : test_tx
   // Receive, clear by software, then overrun and recovery.
   task automatic test_rx();
      peer_byte <= 8'h5A;
      peer_clr <= 1'b1;
      repeat (10) @(posedge clk);
      peer_clr <= 1'b0;
      bus(SU_OFS_CTRL, 8'h50, 1'b1, 1'b0);
      for (int i = 0; i < 300 && rx_irq !== 1'b1; i++) @(posedge clk);
      chk("rx_irq", {rx_irq, irq_top}, {1'b1, SU_IRQ_RX});
      bus(SU_OFS_RXD, 8'h00, 1'b0, 1'b0);
      chk("rx_data", rv, 8'h5A);
      bus(SU_OFS_STAT, 8'hFF, 1'b1, 1'b0);
      bus(SU_OFS_STAT, 8'h00, 1'b0, 1'b0);
      chk("status", rv, 8'hC0);
      bus(SU_OFS_STAT, 8'hBF, 1'b1, 1'b0);
      chk("rx_irq", rx_irq, 1'b0);
      peer_byte <= 8'hC3;
      for (int i = 0; i < 300 && rx_irq !== 1'b1; i++) @(posedge clk);
      chk("rx_irq", rx_irq, 1'b1);
      for (int i = 0; i < 300 && err_irq !== 1'b1; i++) @(posedge clk);
      chk("err_irq", {err_irq, irq_top}, {1'b1, SU_IRQ_ERR});
      bus(SU_OFS_RXD, 8'h00, 1'b0, 1'b1);
      chk("rx_data", rv, 8'h5A);
      chk("rx_irq", rx_irq, 1'b0);
      repeat (150) @(posedge clk);
      chk("rx_irq", rx_irq, 1'b0);
      bus(SU_OFS_STAT, 8'h00, 1'b0, 1'b0);
      chk("status", rv, 8'hA0);
      bus(SU_OFS_STAT, 8'hDF, 1'b1, 1'b0);
      chk("err_irq", err_irq, 1'b0);
      bus(SU_OFS_CTRL, 8'h00, 1'b1, 1'b0);
   endtask : test_rx
   // Pulses on the released clock pin, slow enough for its synchroniser.
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         ext_sck <= 1'b0;
         repeat (6) @(posedge clk);
         ext_sck <= 1'b1;
         repeat (6) @(posedge clk);
      end
   endtask : ext_pulses
   // Pin clock, both directions on: nothing shifts until the empty flag clears, then both run.
   task automatic test_ext();
      peer_byte <= 8'h96;
      bus(SU_OFS_CTRL, 8'h32, 1'b1, 1'b0);
      chk("sck_oe_b", sck_oe_b, 1'b1);
      peer_clr <= 1'b1;
      @(posedge clk);
      peer_clr <= 1'b0;
      ext_pulses(8);
      chk("idle_txd", got_byte, 8'hFF);
      bus(SU_OFS_STAT, 8'h00, 1'b0, 1'b0);
      chk("idle_stat", rv, 8'h80);
      bus(SU_OFS_TXD, 8'h69, 1'b1, 1'b0);
      bus(SU_OFS_STAT, 8'h7F, 1'b1, 1'b0);
      ext_pulses(8);
      chk("ext_byte", got_byte, 8'h69);
      chk("ext_last", txd, 1'b0);
      bus(SU_OFS_RXD, 8'h00, 1'b0, 1'b0);
      chk("ext_rx", rv, 8'h96);
      ext_pulses(1);
      chk("ext_txd", txd, 1'b1);
      bus(SU_OFS_CTRL, 8'h00, 1'b1, 1'b0);
   endtask : test_ext
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      rst_b = 1'b0;
      bus_req = '0;
      peer_byte = 8'h00;
      peer_clr = 1'b0;
      ext_sck = 1'b1;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      test_reset();
      test_tx();
      test_rx();
      test_ext();
      tally_and_finish();
   end
   // The scenarios need about 800 cycles; 25 times that means a hang.
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
endmodule : testbench
